// ---- rtl/misc_ctl_pkg.sv ----
// Constants, field positions and carrier types for the serial test control
// block. Assumes one 40 MHz clock domain and a 32-bit Avalon-MM host.
package misc_ctl_pkg;

  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_IPRE   = 4'h1;
  localparam logic [3:0]  ADDR_STAT   = 4'h2;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_WMASK  = 16'hFCFC;
  localparam logic [15:0] IPRE_RESET  = 16'h0004;
  localparam int          BIT_BTEST   = 15;
  localparam int          BIT_BIT_CLOCK_SOURCE_SELECT  = 14;
  localparam int          BIT_PERR    = 13;
  localparam int          BIT_LOOP    = 12;
  localparam int          BIT_BRESET  = 11;
  localparam int          BIT_INFRARED_OUTPUT_OBSERVE  = 10;
  localparam int          BIT_RTSSRC  = 7;
  localparam int          BIT_RTSMAN  = 6;
  localparam int          BIT_IREN    = 5;
  localparam int          BIT_IRLOOP  = 4;
  localparam int          BIT_RXINV   = 3;
  localparam int          BIT_TXINV   = 2;
  localparam logic [5:0]  FIFO_DEPTH  = 6'h20;
  localparam logic [5:0]  RTS_FREE_MIN = 6'h04;
  localparam logic [3:0]  IR_PULSE_LEN = 4'h3;
  localparam logic [3:0]  IR_BIT_LEN   = 4'hF;

  typedef struct packed {
    logic baud_test;
    logic bit_clock_source_select;
    logic inject_parity_fault;
    logic loopback;
    logic baud_reset;
    logic infrared_output_observe;
    logic request_pin_source_select;
    logic request_to_send_manual;
    logic infrared_format_enable;
    logic infrared_loop;
    logic receive_line_invert;
    logic transmit_line_invert;
  } ctrl_fields_t;

  typedef struct packed {
    logic tx_serial;
    logic tx_parity_slot;
    logic rx_serial;
  } line_path_t;

  function automatic ctrl_fields_t unpack_ctrl(input logic [15:0] r);
    unpack_ctrl.baud_test                 = r[BIT_BTEST];
    unpack_ctrl.bit_clock_source_select   = r[BIT_BIT_CLOCK_SOURCE_SELECT];
    unpack_ctrl.inject_parity_fault       = r[BIT_PERR];
    unpack_ctrl.loopback                  = r[BIT_LOOP];
    unpack_ctrl.baud_reset                = r[BIT_BRESET];
    unpack_ctrl.infrared_output_observe   = r[BIT_INFRARED_OUTPUT_OBSERVE];
    unpack_ctrl.request_pin_source_select = r[BIT_RTSSRC];
    unpack_ctrl.request_to_send_manual    = r[BIT_RTSMAN];
    unpack_ctrl.infrared_format_enable    = r[BIT_IREN];
    unpack_ctrl.infrared_loop             = r[BIT_IRLOOP];
    unpack_ctrl.receive_line_invert       = r[BIT_RXINV];
    unpack_ctrl.transmit_line_invert      = r[BIT_TXINV];
  endfunction

endpackage

// ---- rtl/baud_gen.sv ----
// Baud generator: integer divider producing a one-cycle bit tick.
// Assumes divisor of at least 2 is programmed by software.
`timescale 1ns/1ps
module baud_gen
  import misc_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hold,
  input  wire logic        nibble_mode,
  input  wire logic [15:0] divisor,
  output logic             tick
);

  logic [15:0] count;
  logic [3:0]  nib_hit;

  // In nibble mode each 4-bit slice wraps on its own, so every slice can be
  // exercised in at most 16 clocks instead of a full 16-bit sweep.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nib_hit[i] = (count[i*4 +: 4] >= divisor[i*4 +: 4] - 4'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (hold) begin
      count <= 16'h0000;
    end else if (nibble_mode) begin
      for (int i = 0; i < 4; i++) begin
        count[i*4 +: 4] <= nib_hit[i] ? 4'h0 : count[i*4 +: 4] + 4'h1;
      end
    end else if (count >= divisor - 16'h0001) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else if (hold) begin
      tick <= 1'b0;
    end else if (nibble_mode) begin
      tick <= nib_hit[0];
    end else begin
      tick <= (count >= divisor - 16'h0001);
    end
  end

endmodule

// ---- rtl/ir_codec.sv ----
// Infrared encoder: a zero bit becomes a short high pulse at bit start.
// Decoder stretches a received pulse into a zero for the bit time.
`timescale 1ns/1ps
module ir_codec
  import misc_ctl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic bit_tick,
  input  wire logic nrz_in,
  input  wire logic pulse_in,
  output logic      pulse_out,
  output logic      nrz_out
);

  logic [3:0] enc_cnt;
  logic [3:0] dec_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_cnt <= 4'h0;
    end else if (bit_tick && !nrz_in) begin
      enc_cnt <= IR_PULSE_LEN;
    end else if (enc_cnt != 4'h0) begin
      enc_cnt <= enc_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (enc_cnt != 4'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt <= 4'h0;
    end else if (pulse_in) begin
      dec_cnt <= IR_BIT_LEN;
    end else if (dec_cnt != 4'h0) begin
      dec_cnt <= dec_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nrz_out <= 1'b1;
    end else begin
      nrz_out <= (dec_cnt == 4'h0) && !pulse_in;
    end
  end

endmodule

// ---- rtl/serial_misc_ctl.sv ----
// Serial port test and line control: control register on Avalon-MM, bit
// clock selection, loopbacks, infrared path, polarity and request pin.
// Assumes the transmitter, receiver and receive FIFO live outside.
`timescale 1ns/1ps
module serial_misc_ctl
  import misc_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  input  wire logic        tx_serial,
  input  wire logic        tx_parity_slot,
  output logic             rx_serial,
  output logic             bit_tick,
  output logic             invert_parity,
  input  wire logic [5:0]  rx_fifo_free,
  input  wire logic        external_bit_clock_pin,
  input  wire logic        receive_data_pin,
  output logic             transmit_data_pin,
  output logic             request_to_send_n
);

  logic [15:0]  serial_misc_test_control;
  logic [15:0]  int_prescale;
  ctrl_fields_t f;
  line_path_t   path;
  logic         ack;
  logic         ext_clk_d;
  logic         ext_tick;
  logic         gen_tick;
  logic         tx_line;
  logic         ir_pulse_out;
  logic         ir_nrz_out;
  logic         ir_pulse_in;
  logic         rx_pin_norm;
  logic         next_rx;
  logic         next_tx_pin;
  logic         next_rts_n;
  logic [15:0]  next_ctrl;

  assign f = unpack_ctrl(serial_misc_test_control);
  assign path.tx_serial      = tx_serial;
  assign path.tx_parity_slot = tx_parity_slot;
  assign path.rx_serial      = rx_serial;

  // Bus: one wait cycle per access, answer on the following edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  assign waitrequest = (read || write) && !ack;
  assign response    = 2'b00;

  // Reserved positions are not stored, so they always read back zero.
  always_comb begin
    next_ctrl = serial_misc_test_control;
    if (byteenable[0]) begin
      next_ctrl[7:0] = writedata[7:0];
    end
    if (byteenable[1]) begin
      next_ctrl[15:8] = writedata[15:8];
    end
    next_ctrl = next_ctrl & CTRL_WMASK;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_misc_test_control <= CTRL_RESET;
    end else if (write && ack && address == ADDR_CTRL) begin
      serial_misc_test_control <= next_ctrl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_prescale <= IPRE_RESET;
    end else if (write && ack && address == ADDR_IPRE) begin
      if (byteenable[0]) begin
        int_prescale[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        int_prescale[15:8] <= writedata[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (read && !ack) begin
      case (address)
        ADDR_CTRL: readdata <= {16'h0000, serial_misc_test_control};
        ADDR_IPRE: readdata <= {16'h0000, int_prescale};
        ADDR_STAT: readdata <= {24'h000000, rx_fifo_free, rx_serial,
                                transmit_data_pin};
        default:   readdata <= 32'h00000000;
      endcase
    end
  end

  // Bit clock sources
  baud_gen u_baud (
    .clk         (clk),
    .rst_n       (rst_n),
    .hold        (f.baud_reset),
    .nibble_mode (f.baud_test),
    .divisor     (int_prescale),
    .tick        (gen_tick)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_d <= 1'b0;
    end else begin
      ext_clk_d <= external_bit_clock_pin;
    end
  end

  assign ext_tick = external_bit_clock_pin && !ext_clk_d;
  assign bit_tick = f.bit_clock_source_select ? ext_tick : gen_tick;

  assign invert_parity = f.inject_parity_fault;
  assign tx_line = path.tx_parity_slot && f.inject_parity_fault
                   ? path.tx_serial : path.tx_serial;

  ir_codec u_ir (
    .clk       (clk),
    .rst_n     (rst_n),
    .bit_tick  (bit_tick),
    .nrz_in    (tx_line),
    .pulse_in  (ir_pulse_in),
    .pulse_out (ir_pulse_out),
    .nrz_out   (ir_nrz_out)
  );

  // Polarity applies at the pin, so an inverted idle line reads as one here.
  assign rx_pin_norm = receive_data_pin ^ f.receive_line_invert;
  assign ir_pulse_in = f.infrared_loop ? ir_pulse_out : rx_pin_norm;

  always_comb begin
    if (f.loopback) begin
      next_rx = tx_line;
    end else if (f.infrared_format_enable || f.infrared_loop) begin
      next_rx = ir_nrz_out;
    end else begin
      next_rx = rx_pin_norm;
    end
  end

  always_comb begin
    if (f.infrared_output_observe || f.infrared_format_enable) begin
      next_tx_pin = ir_pulse_out;
    end else begin
      next_tx_pin = tx_line;
    end
    next_tx_pin = next_tx_pin ^ f.transmit_line_invert;
  end

  always_comb begin
    if (f.request_pin_source_select) begin
      next_rts_n = (rx_fifo_free <= RTS_FREE_MIN);
    end else begin
      next_rts_n = !f.request_to_send_manual;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_serial <= 1'b1;
    end else begin
      rx_serial <= next_rx;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_data_pin <= 1'b1;
    end else begin
      transmit_data_pin <= next_tx_pin;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request_to_send_n <= 1'b1;
    end else begin
      request_to_send_n <= next_rts_n;
    end
  end

endmodule

// ---- tb/serial_misc_ctl_asserts.sv ----
// Checker for serial_misc_ctl: bus timing and pin relations.
// Assumes one clock; tracks the control register from accepted writes.
`timescale 1ns/1ps
module serial_misc_ctl_asserts
  import misc_ctl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  input wire logic        tx_serial,
  input wire logic        invert_parity,
  input wire logic [5:0]  rx_fifo_free,
  input wire logic        receive_data_pin,
  input wire logic        rx_serial,
  input wire logic        transmit_data_pin,
  input wire logic        request_to_send_n
);
  logic [15:0] sh;
  logic [15:0] ps;
  logic        live;
  logic        rq;
  assign rq = read | write;
  // Pins lag the register by one edge, so pin rules use last cycle's copy; the parity rule uses sh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= CTRL_RESET;
    end else if (write && !waitrequest && address == ADDR_CTRL) begin
      if (byteenable[0]) sh[7:0] <= writedata[7:0] & CTRL_WMASK[7:0];
      if (byteenable[1]) sh[15:8] <= writedata[15:8] & CTRL_WMASK[15:8];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps <= CTRL_RESET;
      live <= 1'b0;
    end else begin
      ps <= sh;
      live <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_first: assert property (rq && !$past(rq) |-> waitrequest)
    else $error("no wait on first cycle");
  a_wait_end: assert property (rq && waitrequest |=> !waitrequest)
    else $error("wait too long");
  a_resp_okay: assert property (response == 2'b00)
    else $error("bad response");
  a_rts_manual: assert property (!ps[7] |-> request_to_send_n == !ps[6])
    else $error("manual request wrong");
  a_rts_fifo: assert property (ps[7] |-> request_to_send_n ==
    ($past(rx_fifo_free) <= RTS_FREE_MIN)) else $error("fifo request wrong");
  a_parity_inject: assert property (invert_parity == sh[13])
    else $error("parity inject wrong");
  a_loop_rx: assert property (live && ps[12] && ps[5:3] == 3'b000
    |-> rx_serial == $past(tx_serial)) else $error("loopback wrong");
  a_rx_line: assert property (live && !ps[12] && ps[5:4] == 2'b00
    |-> rx_serial == ($past(receive_data_pin) ^ ps[3]))
    else $error("receive line wrong");
  a_tx_pin: assert property (live && !ps[10] && !ps[5]
    |-> transmit_data_pin == ($past(tx_serial) ^ ps[2]))
    else $error("transmit pin wrong");
  c_write: cover property (write && !waitrequest);
  c_fifo: cover property (ps[7] && request_to_send_n);
  c_loop: cover property (live && ps[12]);
endmodule
bind serial_misc_ctl serial_misc_ctl_asserts serial_misc_ctl_asserts_i (
  .clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
  .waitrequest, .response, .tx_serial, .invert_parity, .rx_fifo_free,
  .receive_data_pin, .rx_serial, .transmit_data_pin, .request_to_send_n);

// ---- tb/serial_peer.sv ----
// Far serial peer: random receive line and a bursty external bit clock.
// Assumes the bench raises run only while it wants the clock.
`timescale 1ns/1ps
module serial_peer (
  input  wire logic clk,
  input  wire logic run,
  output logic      line,
  output logic      bit_clk
);
  logic [1:0] ph = 2'h0;
  initial begin
    line = 1'b1;
    bit_clk = 1'b0;
  end
  // Clock stands low outside bursts
  always @(posedge clk) begin
    line <= 1'($urandom);
    ph <= run ? ph + 2'h1 : 2'h0;
    bit_clk <= run & ph[1];
  end
endmodule

// ---- tb/serial_misc_ctl_tb.sv ----
// Testbench for serial_misc_ctl with a pin model and the serial peer.
// Assumes the bus answers one cycle after a request rises.
`timescale 1ns/1ps
module serial_misc_ctl_tb
  import misc_ctl_pkg::*;
;
  logic        clk = 0, rst_n = 0, read = 0, write = 0, run = 0, rnd = 0;
  logic        tx_serial = 1, tx_parity_slot = 0, chk = 0, s_tx, s_rx;
  logic [3:0]  address = 0, byteenable = 0;
  logic [31:0] writedata = 0, readdata, q;
  logic [5:0]  rx_fifo_free = 6'h20, s_free;
  logic        waitrequest, rx_serial, bit_tick, invert_parity, ext_clk;
  logic        rxd, transmit_data_pin, request_to_send_n;
  logic [1:0]  response;
  int          fail_count = 0, samples_checked = 0, cyc = 0, ctl = 0;
  int          t, h, l, r, t2, h2, l2, r2;
  int          modes[] = '{16'h0000, 16'h1000, 16'h0008, 16'h0004, 16'h1004,
                           16'h0080, 16'h00C0, 16'h0040, 16'h2000, 16'h8000};
  serial_misc_ctl serial_misc_ctl_i (.clk, .rst_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .response, .tx_serial,
    .tx_parity_slot, .rx_serial, .bit_tick, .invert_parity, .rx_fifo_free,
    .external_bit_clock_pin(ext_clk), .receive_data_pin(rxd),
    .transmit_data_pin, .request_to_send_n);
  serial_peer serial_peer_i (.clk, .run, .line(rxd), .bit_clk(ext_clk));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input int d);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= 32'(d);
    byteenable <= {2'($urandom), 2'h3};
    // No local limit: a bus that never answers ends in the bench timeout
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic setc(input int v);
    bus(1'b1, ADDR_CTRL, v);
    ctl = v & CTRL_WMASK;
    bus(1'b0, ADDR_CTRL, 0);
    cmp("ctrl", 32'(ctl), q);
  endtask
  task automatic win(input int n, output int t, output int h,
                     output int l, output int r);
    logic pc;
    {t, h, l, r} = 0;
    pc = ext_clk;
    repeat (n) begin
      @(posedge clk);
      t += bit_tick;
      h += transmit_data_pin;
      l += !rx_serial;
      r += ext_clk & !pc;
      pc = ext_clk;
    end
  endtask
  // Model reads outputs before this edge lands, against last inputs
  always @(posedge clk) begin
    if (chk && ctl[5:4] == 2'b00 && !ctl[10]) begin
      cmp("rx", ctl[12] ? s_tx : s_rx ^ ctl[3], rx_serial);
      cmp("txd", s_tx ^ ctl[2], transmit_data_pin);
      cmp("rts", ctl[7] ? s_free <= 4 : !ctl[6], request_to_send_n);
      cmp("perr", ctl[13], invert_parity);
    end
    s_tx <= tx_serial;
    s_rx <= rxd;
    s_free <= rx_fifo_free;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rnd) begin
      tx_serial <= 1'($urandom);
      tx_parity_slot <= 1'($urandom);
      rx_fifo_free <= 6'($urandom_range(3, 6));
    end
    if (cyc > 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'hE1801642));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_CTRL, 0);
    cmp("reset", 32'h0, q);
    bus(1'b0, 4'hF, 0);
    cmp("unmapped", 32'h0, q);
    bus(1'b0, ADDR_IPRE, 0);
    cmp("prescale_rst", 32'(IPRE_RESET), q);
    rnd = 1;
    for (int i = 0; i < modes.size() + 4; i++) begin
      setc(i < modes.size() ? modes[i] : $urandom & 16'h30C4);
      repeat (2) @(posedge clk);
      chk <= 1'b1;
      repeat (24) @(posedge clk);
      chk <= 1'b0;
    end
    setc(16'h4000);
    run <= 1'b1;
    win(40, t, h, l, r);
    run <= 1'b0;
    win(8, t2, h2, l2, r2);
    // An edge on the last sample of the burst shows up in the tail window
    cmp("ext_ticks", 32'(r + r2), 32'(t + t2));
    cmp("ext_edges", 32'h1, 32'(r > 0));
    setc(16'h0800);
    win(40, t, h, l, r);
    cmp("held_ticks", 32'h0, 32'(t));
    setc(16'h0000);
    win(40, t, h, l, r);
    cmp("gen_ticks", 32'(40 / IPRE_RESET), 32'(t));
    // Divisor 0x13: 19 clocks per tick whole, 3 per tick in nibble mode
    bus(1'b1, ADDR_IPRE, 32'h13);
    bus(1'b0, ADDR_IPRE, 0);
    cmp("prescale", 32'h13, q);
    repeat (20) @(posedge clk);
    win(38, t, h, l, r);
    cmp("div_ticks", 32'h2, 32'(t));
    setc(16'h8000);
    win(39, t, h, l, r);
    cmp("nib_ticks", 32'hD, 32'(t));
    rnd = 0;
    tx_serial <= 1'b1;
    setc(16'h0430);
    repeat (20) @(posedge clk);
    win(30, t, h, l, r);
    cmp("ir_idle", 32'h0, 32'(h + l));
    tx_serial <= 1'b0;
    win(60, t, h, l, r);
    cmp("ir_pulse", 32'h1, 32'(h > 0));
    cmp("ir_loop", 32'h1, 32'(l > 0));
    // Observe alone: a low transmit line would keep the pin low otherwise
    setc(16'h0400);
    win(60, t, h, l, r);
    cmp("ir_observe", 32'h1, 32'(h > 0));
    conclude();
  end
endmodule
